// ### design/rgo_gate_output.sv
// Purpose: Reading-gate control and two switching ports driven by ASCII host commands.
// Assumes: Classic Wishbone slave; one clock; synchronous active-low reset.
// Notes:   Command characters are written one per access; replies are read one per access.
//
// Overview of operation
// - Manual close ends gate, emits result, silent.
// - Manually closed gate reports a failed read.
// - Activate command drives port 1 or 2 active.
// - Inversion turns logical high into low pin.
// - Query replies port one then two, semicolon.
// - Queried output state is the last commanded.
// - Field codes: 0, 1, I input, P passive.
// - Set command applies states to output ports.
// - Set values for non-output ports are ignored.
// - Set answers status code 00 to 03.
// - Open command opens gate until a closing event.
// - Each port is configured input, output or passive.
`timescale 1ns/1ps

module rgo_gate_output (
  input  wire logic        I_CLK,
  input  wire logic        I_RESET_N,
  input  wire logic        I_CE,
  input  wire logic        I_WB_CYC,
  input  wire logic        I_WB_STB,
  input  wire logic        I_WB_WE,
  input  wire logic [7:0]  I_WB_ADR,
  input  wire logic [3:0]  I_WB_SEL,
  input  wire logic [31:0] I_WB_DAT,
  input  wire logic        I_SUCCESSFUL_READ,
  input  wire logic        I_AUTO_CLOSE,
  output logic [31:0]      O_WB_DAT,
  output logic             O_WB_ACK,
  output logic             O_GATE_OPEN,
  output logic             O_RESULT_VALID,
  output logic             O_RESULT_FAILED,
  output logic [1:0]       O_SWITCH,
  output logic [1:0]       O_SWITCH_OE
);
  // ---------------------------------------------------------------------------
  // Bus slave decode
  // ---------------------------------------------------------------------------
  logic [7:0]  cfg;
  logic [1:0]  st;
  logic        gate;
  logic        success_seen;
  logic [7:0]  rep [rgo_pkg::LINE_DEPTH];
  logic [3:0]  rep_cnt;
  logic [3:0]  rep_idx;

  wire         wb_go     = I_CE & I_WB_CYC & I_WB_STB & ~O_WB_ACK;
  wire         wr        = wb_go & I_WB_WE & I_WB_SEL[0];
  wire         rd        = wb_go & ~I_WB_WE;
  wire         hit_cmd   = (I_WB_ADR == rgo_pkg::ADDR_CMD);
  wire         hit_cfg   = (I_WB_ADR == rgo_pkg::ADDR_PORT_CFG);
  wire         hit_stat  = (I_WB_ADR == rgo_pkg::ADDR_STATUS);
  wire         hit_rep   = (I_WB_ADR == rgo_pkg::ADDR_REPLY);
  wire         cfg_wr    = wr & hit_cfg;
  wire         rep_pop   = rd & hit_rep & (rep_cnt != 4'h0);
  wire [7:0]   next_cfg  = I_WB_DAT[7:0] & rgo_pkg::CFG_MASK;
  wire [31:0]  stat_word = (32'(gate) << rgo_pkg::ST_GATE_POS) |
                           (32'(O_RESULT_FAILED) << rgo_pkg::ST_FAILED_POS) |
                           (32'(st) << rgo_pkg::ST_STATE_POS) |
                           (32'(rep_cnt) << rgo_pkg::ST_REPCNT_POS);
  wire [31:0]  rep_word  = (rep_cnt != 4'h0) ? {24'h0, rep[rep_idx]} : 32'h0;
  wire [31:0]  next_dat  = hit_cfg ? {24'h0, cfg} : hit_stat ? stat_word : hit_rep ? rep_word : 32'h0;

  // ---------------------------------------------------------------------------
  // Command parser
  // ---------------------------------------------------------------------------
  logic        cmd_open;
  logic        cmd_close;
  logic        cmd_act;
  logic        cmd_clr;
  logic        cmd_query;
  logic        cmd_set;
  logic [1:0]  cmd_sel;
  logic [1:0]  set_mask;
  logic [1:0]  set_val;
  logic [1:0]  set_code;

  rgo_cmd_parse #(
    .DEPTH        (rgo_pkg::LINE_DEPTH)
  ) u_parse (
    .i_clk        (I_CLK),
    .i_reset_n    (I_RESET_N),
    .i_ce         (I_CE),
    .i_char_valid (wr & hit_cmd),
    .i_char       (I_WB_DAT[7:0]),
    .o_open       (cmd_open),
    .o_close      (cmd_close),
    .o_act        (cmd_act),
    .o_clr        (cmd_clr),
    .o_query      (cmd_query),
    .o_set        (cmd_set),
    .o_port_sel   (cmd_sel),
    .o_set_mask   (set_mask),
    .o_set_val    (set_val),
    .o_set_code   (set_code)
  );

  // Acknowledge blocks the next take, so a strobe still held in the ack cycle is never taken twice.
  always_ff @(posedge I_CLK)
  begin
    if (!I_RESET_N)
    begin
      O_WB_ACK <= 1'b0;
      O_WB_DAT <= 32'h0;
      cfg      <= rgo_pkg::CFG_RESET;
    end
    else if (I_CE)
    begin
      O_WB_ACK <= wb_go;
      O_WB_DAT <= rd ? next_dat : 32'h0;
      if (cfg_wr)
        cfg <= next_cfg;
    end
  end

  // ---------------------------------------------------------------------------
  // Reading gate
  // ---------------------------------------------------------------------------
  // A manual close outranks an automatic one in the same cycle, so it always reports a failed read.
  wire         man_close  = cmd_close & gate;
  wire         auto_close = I_AUTO_CLOSE & gate & ~cmd_close;

  always_ff @(posedge I_CLK)
  begin
    if (!I_RESET_N)
    begin
      gate            <= 1'b0;
      success_seen    <= 1'b0;
      O_GATE_OPEN     <= 1'b0;
      O_RESULT_VALID  <= 1'b0;
      O_RESULT_FAILED <= 1'b0;
    end
    else if (I_CE)
    begin
      O_RESULT_VALID <= man_close | auto_close;
      O_GATE_OPEN    <= gate;
      if (man_close | auto_close)
        gate <= 1'b0;
      else if (cmd_open & ~gate)
        gate <= 1'b1;
      if (cmd_open & ~gate)
        success_seen <= 1'b0;
      else if (gate & I_SUCCESSFUL_READ)
        success_seen <= 1'b1;
      if (man_close)
        O_RESULT_FAILED <= 1'b1;
      else if (auto_close)
        O_RESULT_FAILED <= ~(success_seen | I_SUCCESSFUL_READ);
    end
  end

  // ---------------------------------------------------------------------------
  // Switching ports
  // ---------------------------------------------------------------------------
  logic [1:0]  next_st;
  logic [1:0]  is_out;

  // A change of function clears the logical state, so no stale level reaches a newly enabled pin.
  for (genvar i = 0; i < 2; i++)
  begin : g_port
    wire [1:0] func     = cfg[rgo_pkg::CFG_FUNC_POS + 2*i +: 2];
    wire       inv      = cfg[rgo_pkg::CFG_INV_POS + i];
    wire       reconfig = cfg_wr & (next_cfg[rgo_pkg::CFG_FUNC_POS + 2*i +: 2] != func);
    assign is_out[i]  = (func == rgo_pkg::FUNC_OUTPUT);
    assign next_st[i] = reconfig ? 1'b0 :
                        (cmd_act & cmd_sel[i] & is_out[i]) ? 1'b1 :
                        (cmd_clr & cmd_sel[i] & is_out[i]) ? 1'b0 :
                        (cmd_set & set_mask[i] & is_out[i]) ? set_val[i] :
                        st[i];

    always_ff @(posedge I_CLK)
    begin
      if (!I_RESET_N)
      begin
        st[i]          <= 1'b0;
        O_SWITCH[i]    <= 1'b0;
        O_SWITCH_OE[i] <= 1'b0;
      end
      else if (I_CE)
      begin
        st[i]          <= next_st[i];
        O_SWITCH[i]    <= is_out[i] & (st[i] ^ inv);
        O_SWITCH_OE[i] <= is_out[i];
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Reply buffer
  // ---------------------------------------------------------------------------
  function automatic logic [7:0] field_char(input logic [1:0] f, input logic s);
    if (f == rgo_pkg::FUNC_OUTPUT)
      return s ? rgo_pkg::CH_1 : rgo_pkg::CH_0;
    else if (f == rgo_pkg::FUNC_INPUT)
      return rgo_pkg::CH_I;
    else
      return rgo_pkg::CH_P;
  endfunction

  logic [7:0]  msg [rgo_pkg::LINE_DEPTH];

  // Query answer is the port fields in order; set answer carries the status code.
  assign msg[0]  = rgo_pkg::CH_O;
  assign msg[1]  = rgo_pkg::CH_A;
  assign msg[2]  = cmd_query ? rgo_pkg::CH_SP : rgo_pkg::CH_EQ;
  assign msg[3]  = cmd_query ? rgo_pkg::CH_S : rgo_pkg::CH_0;
  assign msg[4]  = cmd_query ? rgo_pkg::CH_1 : (rgo_pkg::CH_0 | {6'h00, set_code});
  assign msg[5]  = rgo_pkg::CH_EQ;
  assign msg[6]  = field_char(cfg[rgo_pkg::CFG_FUNC_POS +: 2], st[0]);
  assign msg[7]  = rgo_pkg::CH_SEMI;
  assign msg[8]  = rgo_pkg::CH_S;
  assign msg[9]  = rgo_pkg::CH_2;
  assign msg[10] = rgo_pkg::CH_EQ;
  assign msg[11] = field_char(cfg[rgo_pkg::CFG_FUNC_POS + 2 +: 2], st[1]);

  always_ff @(posedge I_CLK)
  begin
    if (!I_RESET_N)
    begin
      rep_cnt <= 4'h0;
      rep_idx <= 4'h0;
    end
    else if (I_CE)
    begin
      if (cmd_query | cmd_set)
      begin
        rep     <= msg;
        rep_idx <= 4'h0;
        rep_cnt <= cmd_query ? rgo_pkg::REP_LEN_QUERY : rgo_pkg::REP_LEN_SET;
      end
      else if (rep_pop)
      begin
        rep_idx <= rep_idx + 4'h1;
        rep_cnt <= rep_cnt - 4'h1;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (!I_RESET_N);

  close_failed_read_result_a: assert property (I_CE && man_close |=> !gate && O_RESULT_VALID && O_RESULT_FAILED)
    else $error("Manual close did not give a failed result.");
  close_silent_a: assert property (I_CE && cmd_close && !rep_pop |=> $stable(rep_cnt))
    else $error("Manual close produced a reply.");
  gate_open_a: assert property (I_CE && cmd_open && !gate |=> gate ##0 !O_RESULT_VALID)
    else $error("Open command did not open the gate.");
  act_port_a: assert property (I_CE && cmd_act && !cfg_wr
                               |=> st == ($past(st) | ($past(cmd_sel) & $past(is_out))))
    else $error("Activate command gave a wrong port state.");
  invert_pin_a: assert property (I_CE && is_out[0]
                                 |=> O_SWITCH[0] == ($past(st[0]) ^ $past(cfg[rgo_pkg::CFG_INV_POS])))
    else $error("Port one pin ignores inversion.");
  invert_two_a: assert property (I_CE && is_out[1]
                                 |=> O_SWITCH[1] == ($past(st[1]) ^ $past(cfg[rgo_pkg::CFG_INV_POS + 1])))
    else $error("Port two pin ignores inversion.");
  query_reply_a: assert property (I_CE && cmd_query |=> rep_cnt == 4'hc && rep[7] == 8'h3b && rep_idx == 4'h0)
    else $error("Query reply malformed.");
  set_ignore_a: assert property (I_CE && cmd_set && !cfg_wr && !is_out[1] |=> $stable(st[1]))
    else $error("Set changed a port that is not an output.");
  set_apply_a: assert property (I_CE && cmd_set && set_code == 2'h0 && set_mask[0] && is_out[0] && !cfg_wr
                                |=> st[0] == $past(set_val[0]))
    else $error("Set did not apply the given state.");
  set_reply_a: assert property (I_CE && cmd_set
                                |=> rep_cnt == 4'h5 && rep[4] == (8'h30 | {6'h00, $past(set_code)}))
    else $error("Set reply carries a wrong status code.");
  set_reject_a: assert property (I_CE && cmd_set && set_code != rgo_pkg::CODE_OK && !cfg_wr |=> $stable(st))
    else $error("Refused set command changed a port state.");
  clear_port_a: assert property (I_CE && cmd_clr && !cfg_wr
                                 |=> st == ($past(st) & ~($past(cmd_sel) & $past(is_out))))
    else $error("Clear command gave a wrong port state.");
  auto_close_a: assert property (I_CE && auto_close
                                 |=> !gate && O_RESULT_VALID &&
                                     O_RESULT_FAILED == !$past(success_seen | I_SUCCESSFUL_READ))
    else $error("Automatic close gave a wrong result.");
  gate_pin_a: assert property (I_CE |=> O_GATE_OPEN == $past(gate))
    else $error("Gate output does not follow the gate.");
  port_enable_a: assert property (I_CE |=> O_SWITCH_OE == $past(is_out))
    else $error("Pin enable does not follow the port function.");
  query_input_a: assert property (I_CE && cmd_query && cfg[1:0] == rgo_pkg::FUNC_INPUT
                                  |=> rep[6] == rgo_pkg::CH_I)
    else $error("Input port not reported as an input.");
  hold_state_a: assert property (I_CE && !cmd_act && !cmd_clr && !cmd_set && !cfg_wr |=> $stable(st))
    else $error("Port state changed without a command.");
  ack_pulse_a: assert property (I_CE && O_WB_ACK |=> !O_WB_ACK)
    else $error("Bus acknowledge held for more than one cycle.");

  close_cov_c: cover property (I_CE && man_close);
  query_cov_c: cover property (I_CE && cmd_query);
  set_ok_cov_c: cover property (I_CE && cmd_set && set_code == 2'h0 && set_mask == 2'h3);
  act_cov_c: cover property (I_CE && cmd_act && (cmd_sel & is_out) != 2'h0);
  clear_cov_c: cover property (I_CE && cmd_clr && (cmd_sel & is_out) != 2'h0);
endmodule

// ### design/rgo_pkg.sv
// Purpose: Shared constants for the reading-gate and switching-output command block,
//          and the ASCII command-line parser that feeds it.
// Assumes: Commands arrive one character at a time and each line ends in a carriage return.
// Notes:   The parser holds one line and decodes it when the terminator arrives.
`timescale 1ns/1ps

package rgo_pkg;
  // ---------------------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------------------
  localparam logic [7:0] ADDR_CMD       = 8'h00;
  localparam logic [7:0] ADDR_PORT_CFG  = 8'h04;
  localparam logic [7:0] ADDR_STATUS    = 8'h08;
  localparam logic [7:0] ADDR_REPLY     = 8'h0c;
  localparam int         CFG_FUNC_POS   = 0;
  localparam int         CFG_INV_POS    = 4;
  localparam logic [7:0] CFG_MASK       = 8'h3f;
  localparam logic [7:0] CFG_RESET      = 8'h00;
  localparam int         ST_GATE_POS    = 0;
  localparam int         ST_FAILED_POS  = 1;
  localparam int         ST_STATE_POS   = 4;
  localparam int         ST_REPCNT_POS  = 8;
  // ---------------------------------------------------------------------------
  // Port functions and reply figures
  // ---------------------------------------------------------------------------
  localparam logic [1:0] FUNC_PASSIVE   = 2'h0;
  localparam logic [1:0] FUNC_INPUT     = 2'h1;
  localparam logic [1:0] FUNC_OUTPUT    = 2'h2;
  localparam logic [1:0] CODE_OK        = 2'h0;
  localparam logic [1:0] CODE_SYNTAX    = 2'h1;
  localparam logic [1:0] CODE_PARAM     = 2'h2;
  localparam logic [1:0] CODE_OTHER     = 2'h3;
  localparam int         LINE_DEPTH     = 12;
  localparam logic [3:0] REP_LEN_QUERY  = 4'hc;
  localparam logic [3:0] REP_LEN_SET    = 4'h5;
  // ---------------------------------------------------------------------------
  // Characters
  // ---------------------------------------------------------------------------
  localparam logic [7:0] CH_CR          = 8'h0d;
  localparam logic [7:0] CH_SP          = 8'h20;
  localparam logic [7:0] CH_PLUS        = 8'h2b;
  localparam logic [7:0] CH_MINUS       = 8'h2d;
  localparam logic [7:0] CH_0           = 8'h30;
  localparam logic [7:0] CH_1           = 8'h31;
  localparam logic [7:0] CH_2           = 8'h32;
  localparam logic [7:0] CH_SEMI        = 8'h3b;
  localparam logic [7:0] CH_EQ          = 8'h3d;
  localparam logic [7:0] CH_QUERY       = 8'h3f;
  localparam logic [7:0] CH_A           = 8'h41;
  localparam logic [7:0] CH_D           = 8'h44;
  localparam logic [7:0] CH_I           = 8'h49;
  localparam logic [7:0] CH_O           = 8'h4f;
  localparam logic [7:0] CH_P           = 8'h50;
  localparam logic [7:0] CH_S           = 8'h53;
endpackage

module rgo_cmd_parse #(
  parameter int DEPTH = rgo_pkg::LINE_DEPTH
) (
  input  wire logic       i_clk,
  input  wire logic       i_reset_n,
  input  wire logic       i_ce,
  input  wire logic       i_char_valid,
  input  wire logic [7:0] i_char,
  output logic            o_open,
  output logic            o_close,
  output logic            o_act,
  output logic            o_clr,
  output logic            o_query,
  output logic            o_set,
  output logic [1:0]      o_port_sel,
  output logic [1:0]      o_set_mask,
  output logic [1:0]      o_set_val,
  output logic [1:0]      o_set_code
);
  localparam int LW = $clog2(DEPTH + 1);

  logic [7:0]    line [DEPTH];
  logic [LW-1:0] len;
  logic          ovf;

  wire           take      = i_ce & i_char_valid;
  wire           eol       = take & (i_char == rgo_pkg::CH_CR);
  wire           len1      = (len == LW'(1));
  wire           len3      = (len == LW'(3));
  wire           len7      = (len == LW'(7));
  wire           len12     = (len == LW'(12));
  wire           state_cmd = (line[0] == rgo_pkg::CH_O) & (line[1] == rgo_pkg::CH_A);
  wire           clear_cmd = (line[0] == rgo_pkg::CH_O) & (line[1] == rgo_pkg::CH_D);
  wire [1:0]     sel       = {line[2] == rgo_pkg::CH_2, line[2] == rgo_pkg::CH_1};
  wire           set_pre   = state_cmd & (len >= LW'(4)) & (line[2] == rgo_pkg::CH_SP);
  wire           f1_ok     = (line[3] == rgo_pkg::CH_S) & (line[5] == rgo_pkg::CH_EQ);
  wire [1:0]     f1_port   = {line[4] == rgo_pkg::CH_2, line[4] == rgo_pkg::CH_1};
  wire           one_field = len7 & f1_ok & (f1_port != 2'h0);
  wire           two_field = len12 & f1_ok & f1_port[0] & (line[7] == rgo_pkg::CH_SEMI) &
                             (line[8] == rgo_pkg::CH_S) & (line[9] == rgo_pkg::CH_2) &
                             (line[10] == rgo_pkg::CH_EQ);
  wire           v1_ok     = (line[6] == rgo_pkg::CH_0) | (line[6] == rgo_pkg::CH_1);
  wire           v2_ok     = (line[11] == rgo_pkg::CH_0) | (line[11] == rgo_pkg::CH_1);
  wire           vals_ok   = two_field ? (v1_ok & v2_ok) : v1_ok;
  wire [1:0]     mask      = two_field ? 2'h3 : f1_port;
  wire [1:0]     vals      = two_field ? {line[11] == rgo_pkg::CH_1, line[6] == rgo_pkg::CH_1}
                                       : {2{line[6] == rgo_pkg::CH_1}};
  wire [1:0]     code      = ovf ? rgo_pkg::CODE_OTHER :
                             !(one_field | two_field) ? rgo_pkg::CODE_SYNTAX :
                             !vals_ok ? rgo_pkg::CODE_PARAM : rgo_pkg::CODE_OK;

  // Line capture; an over-long line is remembered so that it can be refused.
  always_ff @(posedge i_clk)
  begin
    if (!i_reset_n)
    begin
      len <= '0;
      ovf <= 1'b0;
    end
    else if (take)
    begin
      if (eol)
      begin
        len <= '0;
        ovf <= 1'b0;
      end
      else if (len == LW'(DEPTH))
        ovf <= 1'b1;
      else
      begin
        line[len] <= i_char;
        len       <= len + 1'b1;
      end
    end
  end

  // One-cycle command pulses, decoded when the terminator arrives.
  always_ff @(posedge i_clk)
  begin
    if (!i_reset_n)
    begin
      o_open     <= 1'b0;
      o_close    <= 1'b0;
      o_act      <= 1'b0;
      o_clr      <= 1'b0;
      o_query    <= 1'b0;
      o_set      <= 1'b0;
      o_port_sel <= 2'h0;
      o_set_mask <= 2'h0;
      o_set_val  <= 2'h0;
      o_set_code <= rgo_pkg::CODE_OK;
    end
    else if (i_ce)
    begin
      o_open     <= eol & ~ovf & len1 & (line[0] == rgo_pkg::CH_PLUS);
      o_close    <= eol & ~ovf & len1 & (line[0] == rgo_pkg::CH_MINUS);
      o_act      <= eol & ~ovf & len3 & state_cmd & (sel != 2'h0);
      o_clr      <= eol & ~ovf & len3 & clear_cmd & (sel != 2'h0);
      o_query    <= eol & ~ovf & len3 & state_cmd & (line[2] == rgo_pkg::CH_QUERY);
      o_set      <= eol & (set_pre | (ovf & state_cmd));
      o_port_sel <= sel;
      o_set_mask <= (code == rgo_pkg::CODE_OK) ? mask : 2'h0;
      o_set_val  <= vals;
      o_set_code <= code;
    end
  end
endmodule

// ### test/rgo_host.sv
// Purpose: Host controller model that issues ASCII command lines over classic Wishbone.
// Assumes: The slave answers each request with a one-cycle ack.
// Notes:   Every wait is bounded; an overrun is counted in timeouts.
`timescale 1ns/1ps

module rgo_host (
  input  wire logic        i_clk,
  input  wire logic        i_ack,
  input  wire logic [31:0] i_dat,
  output logic             o_cyc,
  output logic             o_stb,
  output logic             o_we,
  output logic [7:0]       o_adr,
  output logic [3:0]       o_sel,
  output logic [31:0]      o_dat
);
  int timeouts = 0;

  initial
  begin
    o_cyc = 1'b0;
    o_stb = 1'b0;
    o_we  = 1'b0;
    o_adr = 8'h00;
    o_sel = 4'h0;
    o_dat = 32'h0000_0000;
  end

  // Holds the request until ack is sampled, then releases; released data is inverted.
  task automatic access(input logic we, input logic [7:0] adr, input logic [31:0] wdat, output logic [31:0] rdat);
    int n;
    @(posedge i_clk);
    o_cyc <= 1'b1;
    o_stb <= 1'b1;
    o_we  <= we;
    o_adr <= adr;
    o_sel <= 4'hf;
    o_dat <= wdat;
    for (n = 0; n < 64; n++)
    begin
      @(posedge i_clk);
      if (i_ack === 1'b1) break;
    end
    if (n == 64) timeouts++;
    rdat = i_dat;
    o_cyc <= 1'b0;
    o_stb <= 1'b0;
    o_we  <= 1'b0;
    o_dat <= ~wdat;
  endtask

  // Sends one command line with its terminator, then lets the command settle.
  task automatic send_line(input string s);
    logic [31:0] rd;
    foreach (s[i]) access(1'b1, rgo_pkg::ADDR_CMD, {24'h000000, s[i]}, rd);
    access(1'b1, rgo_pkg::ADDR_CMD, {24'h000000, rgo_pkg::CH_CR}, rd);
    repeat (5) @(posedge i_clk);
  endtask
endmodule

// ### test/tb.sv
// Purpose: Self-checking bench for the reading-gate and switching-port command block.
// Assumes: 200 MHz clock, synchronous active-low reset held 20 cycles.
// Notes:   Port settings and set values are drawn from an LFSR with a fixed start.
`timescale 1ns/1ps

module tb;
  logic I_CLK = 1'b0, I_RESET_N = 1'b0, I_CE = 1'b1, I_SUCCESSFUL_READ = 1'b0, I_AUTO_CLOSE = 1'b0;
  logic cyc, stb, we, ack, gate, rvalid, rfail;
  logic [7:0]  adr;
  logic [3:0]  sel;
  logic [31:0] wdat, rdat, rd, rng;
  logic [1:0]  sw, oe, st, inv, fn [2];
  logic        p, a, b;
  int          err_total = 0, checks = 0, pulses = 0, n0, k;
  string       line;

  always #2.5 I_CLK = ~I_CLK;
  always @(posedge I_CLK) if (rvalid === 1'b1) pulses++;
  always @(posedge I_CLK) if (rgo_host_inst.timeouts != 0) test_done();

  rgo_host rgo_host_inst (.i_clk(I_CLK), .i_ack(ack), .i_dat(rdat), .o_cyc(cyc), .o_stb(stb), .o_we(we),
                          .o_adr(adr), .o_sel(sel), .o_dat(wdat));
  rgo_gate_output rgo_gate_output_inst (.I_CLK(I_CLK), .I_RESET_N(I_RESET_N), .I_CE(I_CE), .I_WB_CYC(cyc),
    .I_WB_STB(stb), .I_WB_WE(we), .I_WB_ADR(adr), .I_WB_SEL(sel), .I_WB_DAT(wdat),
    .I_SUCCESSFUL_READ(I_SUCCESSFUL_READ), .I_AUTO_CLOSE(I_AUTO_CLOSE), .O_WB_DAT(rdat), .O_WB_ACK(ack),
    .O_GATE_OPEN(gate), .O_RESULT_VALID(rvalid), .O_RESULT_FAILED(rfail), .O_SWITCH(sw), .O_SWITCH_OE(oe));

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], 1'b0} ^ (x[31] ? 32'h04c11db7 : 32'h0);
  endfunction

  function automatic string fchar(input int i);
    if (fn[i] == rgo_pkg::FUNC_OUTPUT) return st[i] ? "1" : "0";
    return (fn[i] == rgo_pkg::FUNC_INPUT) ? "I" : "P";
  endfunction

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic check_ports();
    logic [1:0] o;
    o = {fn[1] == rgo_pkg::FUNC_OUTPUT, fn[0] == rgo_pkg::FUNC_OUTPUT};
    rgo_host_inst.access(1'b0, rgo_pkg::ADDR_STATUS, 32'h0, rd);
    cmp({30'h0, rd[5:4]}, {30'h0, st});
    cmp({30'h0, sw}, {30'h0, o & (st ^ inv)});
    cmp({30'h0, oe}, {30'h0, o});
  endtask

  task automatic check_reply(input string e);
    rgo_host_inst.access(1'b0, rgo_pkg::ADDR_STATUS, 32'h0, rd);
    cmp({28'h0, rd[11:8]}, 32'(e.len()));
    foreach (e[i])
    begin
      rgo_host_inst.access(1'b0, rgo_pkg::ADDR_REPLY, 32'h0, rd);
      cmp(rd, {24'h0, e[i]});
    end
    rgo_host_inst.access(1'b0, rgo_pkg::ADDR_REPLY, 32'h0, rd);
    cmp(rd, 32'h0);
  endtask

  // Writes a port setting, mirrors it in the expected state and reads it back.
  task automatic put_cfg(input logic [5:0] c);
    for (int i = 0; i < 2; i++)
    begin
      if (c[2*i+:2] != fn[i]) st[i] = 1'b0;
      fn[i] = c[2*i+:2];
    end
    inv = c[5:4];
    rgo_host_inst.access(1'b1, rgo_pkg::ADDR_PORT_CFG, {26'h0, c}, rd);
    rgo_host_inst.access(1'b0, rgo_pkg::ADDR_PORT_CFG, 32'h0, rd);
    cmp(rd, {26'h0, c});
  endtask

  task automatic test_done();
    err_total += rgo_host_inst.timeouts;
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  initial
  begin
    repeat (50000) @(posedge I_CLK);
    err_total++;
    test_done();
  end

  initial
  begin
    rng = 32'h1b103392;
    st = 2'b00;
    inv = 2'b00;
    fn[0] = rgo_pkg::FUNC_PASSIVE;
    fn[1] = rgo_pkg::FUNC_PASSIVE;
    repeat (20) @(posedge I_CLK);
    I_RESET_N <= 1'b1;
    // ---------------------------------------------------------------------------
    // Reset values and an unmapped address
    // ---------------------------------------------------------------------------
    rgo_host_inst.access(1'b0, rgo_pkg::ADDR_PORT_CFG, 32'h0, rd);
    cmp(rd, {24'h0, rgo_pkg::CFG_RESET});
    rgo_host_inst.access(1'b1, 8'h10, 32'h3f, rd);
    rgo_host_inst.access(1'b0, 8'h10, 32'h0, rd);
    cmp(rd, 32'h0);
    check_ports();
    $display("test reset done");
    // ---------------------------------------------------------------------------
    // Gate: manual close, close while closed, automatic close
    // ---------------------------------------------------------------------------
    rgo_host_inst.send_line("+");
    cmp({31'h0, gate}, 32'h1);
    n0 = pulses;
    rgo_host_inst.send_line("-");
    cmp(32'(pulses - n0), 32'h1);
    cmp({31'h0, rfail}, 32'h1);
    cmp({31'h0, gate}, 32'h0);
    check_reply("");
    rgo_host_inst.send_line("-");
    cmp(32'(pulses - n0), 32'h1);
    rgo_host_inst.send_line("+");
    @(posedge I_CLK);
    I_SUCCESSFUL_READ <= 1'b1;
    repeat (3) @(posedge I_CLK);
    I_AUTO_CLOSE <= 1'b1;
    @(posedge I_CLK);
    I_AUTO_CLOSE <= 1'b0;
    I_SUCCESSFUL_READ <= 1'b0;
    repeat (5) @(posedge I_CLK);
    cmp(32'(pulses - n0), 32'h2);
    cmp({31'h0, rfail}, 32'h0);
    cmp({31'h0, gate}, 32'h0);
    $display("test gate done");
    // ---------------------------------------------------------------------------
    // Random port settings with activate, query and set
    // ---------------------------------------------------------------------------
    for (k = 0; k < 12; k++)
    begin
      rng = lfsr(rng);
      put_cfg((k == 0) ? 6'h3a : rng[5:0]);
      p = rng[8];
      rgo_host_inst.send_line(p ? "OA2" : "OA1");
      if (fn[p] == rgo_pkg::FUNC_OUTPUT) st[p] = 1'b1;
      check_ports();
      check_reply("");
      rgo_host_inst.send_line("OA?");
      check_reply({"OA S1=", fchar(0), ";S2=", fchar(1)});
      a = rng[9];
      b = rng[10];
      // Fields are always listed in ascending port order.
      case (rng[12:11])
        2'h0: line = $sformatf("OA S1=%0d", a);
        2'h1: line = $sformatf("OA S2=%0d", b);
        default: line = $sformatf("OA S1=%0d;S2=%0d", a, b);
      endcase
      rgo_host_inst.send_line(line);
      if (rng[12:11] != 2'h1 && fn[0] == rgo_pkg::FUNC_OUTPUT) st[0] = a;
      if (rng[12:11] != 2'h0 && fn[1] == rgo_pkg::FUNC_OUTPUT) st[1] = b;
      check_reply("OA=00");
      check_ports();
    end
    $display("test ports done");
    // ---------------------------------------------------------------------------
    // Clear command, then refused set commands leave the states alone
    // ---------------------------------------------------------------------------
    put_cfg(6'h0a);
    rgo_host_inst.send_line("OA S1=1;S2=1");
    st = 2'h3;
    check_reply("OA=00");
    rgo_host_inst.send_line("OD1");
    st[0] = 1'b0;
    check_reply("");
    check_ports();
    rgo_host_inst.send_line("OA S1=5");
    check_reply("OA=02");
    rgo_host_inst.send_line("OA S3=1");
    check_reply("OA=01");
    rgo_host_inst.send_line("OA S1=1;S2=10");
    check_reply("OA=03");
    check_ports();
    $display("test set error done");
    test_done();
  end
endmodule
